// file: rtl/sfgs_top.sv
// Notch, adaptive suppression, torque low-pass and gain changing control
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`include "sfgs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module sfgs_top
	import sfgs_pkg::*;
#(
	parameter logic [39:0] SAVE_CYCLES = `SFGS_SAVE_MIN * `SFGS_S_PER_MIN * `SFGS_CLK_HZ,
	parameter logic [15:0] MS_CYCLES   = 16'(`SFGS_CLK_HZ / `SFGS_MS_PER_S)
) (
	// Clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	// Wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [6:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic [31:0]      o_wb_dat,
	output logic             o_wb_ack,
	// Gain change condition sources
	input  wire logic        i_ext_gain_sel,
	input  wire sfgs_word_t  i_cmd_freq_kpps,
	input  wire sfgs_word_t  i_droop_pulses,
	input  wire sfgs_word_t  i_motor_speed_rpm,
	// Resonance detector
	input  wire logic        i_res_valid,
	input  wire sfgs_word_t  i_res_freq_hz,
	input  wire sfgs_word_t  i_res_mag,
	// Nonvolatile store
	input  wire logic        i_nv_load_valid,
	input  wire sfgs_word_t  i_nv_load_freq,
	input  wire logic [1:0]  i_nv_load_depth,
	output logic             o_nv_save,
	output sfgs_word_t       o_nv_freq,
	output logic [1:0]       o_nv_depth,
	// Torque command
	input  wire logic        i_torque_valid,
	input  wire sfgs_word_t  i_torque,
	output logic             o_torque_valid,
	output sfgs_word_t       o_torque,
	// Notch settings to the filter path
	output logic [7:0]       o_notch1_freq,
	output logic [1:0]       o_notch1_depth,
	output logic [7:0]       o_notch2_freq,
	output logic [1:0]       o_notch2_depth,
	output logic             o_adapt_active,
	output sfgs_word_t       o_adapt_freq,
	output logic [1:0]       o_adapt_depth,
	// Active loop gains
	output sfgs_word_t       o_model_pos_gain,
	output sfgs_word_t       o_model_spd_gain,
	output sfgs_word_t       o_act_inertia,
	output sfgs_word_t       o_act_pos_gain,
	output sfgs_word_t       o_act_spd_gain,
	output sfgs_word_t       o_act_int_time,
	output logic             o_gain_changed
);
	// ********
	// Decode helpers
	// ********
	// Frequency field of a notch setting
	function automatic logic [7:0] notch_freq(input sfgs_word_t code);
		notch_freq = code[`SFGS_NOTCH_FREQ];
	endfunction : notch_freq
	// Depth field of a notch setting
	function automatic logic [1:0] notch_depth(input sfgs_word_t code);
		notch_depth = code[`SFGS_NOTCH_DEPTH];
	endfunction : notch_depth
	// Changed gain from base and percent, clamped to the word
	function automatic sfgs_word_t scale_pct(input sfgs_word_t base, input sfgs_word_t pct);
		logic [31:0] prod;
		prod = (32'(base) * 32'(pct)) / `SFGS_PCT_DIV;
		scale_pct = (prod > `SFGS_GAIN_MAX) ? 16'hFFFF : prod[15:0];
	endfunction : scale_pct

	// ********
	// Register file and bus slave
	// ********
	sfgs_word_t  cfg_ff [`SFGS_N_CFG];
	logic        ack_ff;
	logic [31:0] rdat_ff;
	logic [4:0]  idx;
	logic        req;
	sfgs_word_t  status_word;
	sfgs_word_t  lpf_hz_ff;
	logic        changed_ff;
	sfgs_word_t  adapt_freq_ff;
	logic [1:0]  adapt_depth_ff;

	assign idx = i_wb_adr[6:2];
	assign req = i_wb_cyc && i_wb_stb && !ack_ff;
	assign status_word = {changed_ff, 13'h0000, adapt_depth_ff};

	// Parameter writes, byte lanes 0 and 1 only; suppression word resets to 0000
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			for (int k = 0; k < `SFGS_N_CFG; k++) begin
				cfg_ff[k] <= `SFGS_RST_ZERO;
			end
			cfg_ff[`SFGS_I_POS_PCT] <= `SFGS_RST_PCT;
			cfg_ff[`SFGS_I_SPD_PCT] <= `SFGS_RST_PCT;
			cfg_ff[`SFGS_I_INT_PCT] <= `SFGS_RST_PCT;
		end else if (req && i_wb_we && idx < 5'(`SFGS_N_CFG)) begin
			if (i_wb_sel[0]) begin
				cfg_ff[idx][7:0] <= i_wb_dat[7:0];
			end
			if (i_wb_sel[1]) begin
				cfg_ff[idx][15:8] <= i_wb_dat[15:8];
			end
		end
	end

	// One-cycle ack; unmapped reads return zero, writes there are dropped
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ack_ff  <= 1'b0;
			rdat_ff <= 32'h0000_0000;
		end else begin
			ack_ff  <= req;
			rdat_ff <= 32'h0000_0000;
			if (req && !i_wb_we) begin
				if (idx < 5'(`SFGS_N_CFG)) begin
					rdat_ff <= {16'h0000, cfg_ff[idx]};
				end else begin
					case (idx)
						`SFGS_I_ACT_INERTIA: rdat_ff <= {16'h0000, o_act_inertia};
						`SFGS_I_ACT_POS:     rdat_ff <= {16'h0000, o_act_pos_gain};
						`SFGS_I_ACT_SPD:     rdat_ff <= {16'h0000, o_act_spd_gain};
						`SFGS_I_ACT_INT:     rdat_ff <= {16'h0000, o_act_int_time};
						`SFGS_I_LPF_HZ:      rdat_ff <= {16'h0000, lpf_hz_ff};
						`SFGS_I_ADAPT_FREQ:  rdat_ff <= {16'h0000, adapt_freq_ff};
						`SFGS_I_STATUS:      rdat_ff <= {16'h0000, status_word};
						default:             rdat_ff <= 32'h0000_0000;
					endcase
				end
			end
		end
	end

	assign o_wb_ack = ack_ff;
	assign o_wb_dat = rdat_ff;

	// ********
	// Notch and adaptive suppression
	// ********
	sfgs_adapt_t adapt_mode;
	logic [3:0]  sens;
	logic        in_band;
	logic [15:0] mag_thr;
	logic [1:0]  new_depth;

	assign adapt_mode = sfgs_adapt_t'(cfg_ff[`SFGS_I_SUPPRESS][`SFGS_SUP_ADAPT]);
	assign sens       = cfg_ff[`SFGS_I_SUPPRESS][`SFGS_SUP_SENS];
	// Band edges are inclusive
	assign in_band = i_res_freq_hz >= `SFGS_BAND_LO_HZ
		&& i_res_freq_hz <= `SFGS_BAND_HI_HZ;
	// Each sensitivity step halves the magnitude needed
	assign mag_thr = `SFGS_MAG_BASE >> sens;

	// Bigger resonance gets a deeper notch
	always_comb begin
		if (i_res_mag >= 16'(mag_thr << 2)) begin
			new_depth = `SFGS_DEPTH_DEEP;
		end else if (i_res_mag >= 16'(mag_thr << 1)) begin
			new_depth = `SFGS_DEPTH_MID;
		end else begin
			new_depth = `SFGS_DEPTH_LOW;
		end
	end

	// Adaptive characteristics: stored value first, then live tracking
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			adapt_freq_ff  <= `SFGS_RST_ZERO;
			adapt_depth_ff <= `SFGS_DEPTH_LOW;
		end else if (i_nv_load_valid) begin
			adapt_freq_ff  <= i_nv_load_freq;
			adapt_depth_ff <= i_nv_load_depth;
		end else if (adapt_mode == SFGS_ADAPT_ON && i_res_valid && in_band
			&& i_res_mag >= mag_thr) begin
			if (i_res_freq_hz != adapt_freq_ff || new_depth != adapt_depth_ff) begin
				adapt_freq_ff  <= i_res_freq_hz;
				adapt_depth_ff <= new_depth;
			end
		end
	end

	// Notch outputs; the first notch is forced off under adaptive control
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_notch1_freq  <= 8'h00;
			o_notch1_depth <= 2'h0;
			o_notch2_freq  <= 8'h00;
			o_notch2_depth <= 2'h0;
			o_adapt_active <= 1'b0;
			o_adapt_freq   <= `SFGS_RST_ZERO;
			o_adapt_depth  <= 2'h0;
		end else begin
			if (adapt_mode != SFGS_ADAPT_OFF) begin
				o_notch1_freq  <= 8'h00;
				o_notch1_depth <= 2'h0;
			end else begin
				o_notch1_freq  <= notch_freq(cfg_ff[`SFGS_I_NOTCH1]);
				o_notch1_depth <= notch_depth(cfg_ff[`SFGS_I_NOTCH1]);
			end
			o_notch2_freq  <= notch_freq(cfg_ff[`SFGS_I_NOTCH2]);
			o_notch2_depth <= notch_depth(cfg_ff[`SFGS_I_NOTCH2]);
			o_adapt_active <= adapt_mode != SFGS_ADAPT_OFF;
			o_adapt_freq   <= adapt_freq_ff;
			o_adapt_depth  <= adapt_depth_ff;
		end
	end

	// ********
	// Periodic save of adaptive result
	// ********
	logic [39:0] save_cnt_ff;

	// Count from reset release; 60 minutes overflows 32 bits at this clock
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			save_cnt_ff <= 40'h00_0000_0000;
			o_nv_save   <= 1'b0;
			o_nv_freq   <= `SFGS_RST_ZERO;
			o_nv_depth  <= 2'h0;
		end else begin
			o_nv_save <= 1'b0;
			if (save_cnt_ff >= SAVE_CYCLES - 40'h1) begin
				save_cnt_ff <= 40'h00_0000_0000;
				o_nv_save   <= 1'b1;
				o_nv_freq   <= adapt_freq_ff;
				o_nv_depth  <= adapt_depth_ff;
			end else begin
				save_cnt_ff <= save_cnt_ff + 40'h1;
			end
		end
	end

	// ********
	// Gain change condition
	// ********
	sfgs_trig_t trig;
	logic       cond;
	logic       manual;

	assign trig   = sfgs_trig_t'(cfg_ff[`SFGS_I_SELECT][`SFGS_SEL_TRIG]);
	assign manual = cfg_ff[`SFGS_I_TUNING][`SFGS_TUNE_MODE] == `SFGS_TUNE_MANUAL;

	// Threshold unit follows the chosen source
	always_comb begin
		case (trig)
			SFGS_TRIG_EXT:   cond = i_ext_gain_sel;
			SFGS_TRIG_CMD:   cond = i_cmd_freq_kpps >= cfg_ff[`SFGS_I_THRESHOLD];
			SFGS_TRIG_DROOP: cond = i_droop_pulses >= cfg_ff[`SFGS_I_THRESHOLD];
			SFGS_TRIG_SPEED: cond = i_motor_speed_rpm >= cfg_ff[`SFGS_I_THRESHOLD];
			default:         cond = 1'b0;
		endcase
	end

	// Auto tuning rewrites gains itself, so changing is held off outside manual
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			changed_ff <= 1'b0;
		end else begin
			changed_ff <= cond && manual;
		end
	end

	assign o_gain_changed = changed_ff;

	// ********
	// Target gains and smoothing
	// ********
	sfgs_word_t tgt [4];
	sfgs_word_t act [4];
	logic [15:0] ms_cnt_ff;
	logic        ms_tick;
	logic        snap_ff;

	// Base or changed targets
	always_comb begin
		tgt[0] = changed_ff ? cfg_ff[`SFGS_I_INERTIA_CHG] : cfg_ff[`SFGS_I_INERTIA];
		tgt[1] = cfg_ff[`SFGS_I_LOOP_POS];
		tgt[2] = cfg_ff[`SFGS_I_LOOP_SPD];
		tgt[3] = cfg_ff[`SFGS_I_INTEGRAL];
		if (changed_ff) begin
			tgt[1] = scale_pct(cfg_ff[`SFGS_I_LOOP_POS], cfg_ff[`SFGS_I_POS_PCT]);
			tgt[2] = scale_pct(cfg_ff[`SFGS_I_LOOP_SPD], cfg_ff[`SFGS_I_SPD_PCT]);
			tgt[3] = scale_pct(cfg_ff[`SFGS_I_INTEGRAL], cfg_ff[`SFGS_I_INT_PCT]);
		end
	end

	// Millisecond tick for the lag filters
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ms_cnt_ff <= 16'h0000;
			snap_ff   <= 1'b1;
		end else begin
			snap_ff   <= 1'b0;
			ms_cnt_ff <= ms_tick ? 16'h0000 : ms_cnt_ff + 16'h0001;
		end
	end

	assign ms_tick = ms_cnt_ff >= MS_CYCLES - 16'h0001;

	// One lag per switched gain; first cycle after reset jumps to target
	for (genvar g = 0; g < 4; g++) begin : g_lag
		sfgs_lag u_lag (
			.i_sys_clk (i_sys_clk),
			.i_rst_n   (i_rst_n),
			.i_snap    (snap_ff),
			.i_tick    (ms_tick),
			.i_tc_ms   (cfg_ff[`SFGS_I_TIME_CONST]),
			.i_target  (tgt[g]),
			.o_value   (act[g])
		);
	end

	assign o_act_inertia  = act[0];
	assign o_act_pos_gain = act[1];
	assign o_act_spd_gain = act[2];
	assign o_act_int_time = act[3];
	// Model gains bypass the changing path entirely
	assign o_model_pos_gain = cfg_ff[`SFGS_I_MODEL_POS];
	assign o_model_spd_gain = cfg_ff[`SFGS_I_MODEL_SPD];

	// ********
	// Torque command low-pass
	// ********
	logic [39:0]        hz_full;
	logic [39:0]        alpha_full;
	logic [16:0]        alpha_ff;
	logic signed [31:0] y_ff;
	logic signed [32:0] err;
	logic signed [50:0] prod;
	logic               lpf_on;

	assign lpf_on = cfg_ff[`SFGS_I_SUPPRESS][`SFGS_SUP_LPF] != `SFGS_LPF_OFF;
	// Cutoff follows the active speed gain and inertia ratio
	assign hz_full = (40'(act[2]) * `SFGS_LPF_NUM)
		/ (`SFGS_TWO_PI_MILLI * (40'(act[0]) + 40'(`SFGS_INERTIA_ONE)));
	assign alpha_full = (40'(lpf_hz_ff) * `SFGS_TWO_PI_Q16) / `SFGS_TORQUE_FS_HZ;
	assign err  = $signed({i_torque[15], i_torque, 16'h0000}) - $signed({y_ff[31], y_ff});
	assign prod = 51'(err * $signed({1'b0, alpha_ff}));

	// Cutoff and coefficient, pipelined one stage each
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			lpf_hz_ff <= `SFGS_RST_ZERO;
			alpha_ff  <= 17'h00000;
		end else begin
			lpf_hz_ff <= (hz_full > 40'h00_0000_FFFF) ? 16'hFFFF : hz_full[15:0];
			alpha_ff  <= (alpha_full > `SFGS_ALPHA_MAX) ? 17'h10000 : alpha_full[16:0];
		end
	end

	// Filter state in Q16; bypass hands the raw sample through
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			y_ff           <= 32'sh0;
			o_torque       <= `SFGS_RST_ZERO;
			o_torque_valid <= 1'b0;
		end else begin
			o_torque_valid <= i_torque_valid;
			if (i_torque_valid) begin
				if (lpf_on) begin
					y_ff     <= 32'(y_ff + 32'(prod >>> 16));
					o_torque <= 16'(32'(y_ff + 32'(prod >>> 16)) >>> 16);
				end else begin
					y_ff     <= {i_torque, 16'h0000};
					o_torque <= i_torque;
				end
			end
		end
	end
endmodule : sfgs_top
`default_nettype wire

// file: common/sfgs_map.svh
// Register offsets, field positions, reset values and timing for the servo filter block
`ifndef SFGS_MAP_SVH
`define SFGS_MAP_SVH
// ********
// Register word indices (byte address = index * 4)
// ********
`define SFGS_I_NOTCH1      5'h00
`define SFGS_I_NOTCH2      5'h01
`define SFGS_I_SUPPRESS    5'h02
`define SFGS_I_TUNING      5'h03
`define SFGS_I_MODEL_POS   5'h04
`define SFGS_I_MODEL_SPD   5'h05
`define SFGS_I_INERTIA     5'h06
`define SFGS_I_LOOP_POS    5'h07
`define SFGS_I_LOOP_SPD    5'h08
`define SFGS_I_INTEGRAL    5'h09
`define SFGS_I_INERTIA_CHG 5'h0A
`define SFGS_I_POS_PCT     5'h0B
`define SFGS_I_SPD_PCT     5'h0C
`define SFGS_I_INT_PCT     5'h0D
`define SFGS_I_SELECT      5'h0E
`define SFGS_I_THRESHOLD   5'h0F
`define SFGS_I_TIME_CONST  5'h10
`define SFGS_N_CFG         17
`define SFGS_I_ACT_INERTIA 5'h11
`define SFGS_I_ACT_POS     5'h12
`define SFGS_I_ACT_SPD     5'h13
`define SFGS_I_ACT_INT     5'h14
`define SFGS_I_LPF_HZ      5'h15
`define SFGS_I_ADAPT_FREQ  5'h16
`define SFGS_I_STATUS      5'h17
// ********
// Field positions
// ********
`define SFGS_NOTCH_FREQ    7:0
`define SFGS_NOTCH_DEPTH   9:8
`define SFGS_SUP_LPF       3:0
`define SFGS_SUP_SENS      7:4
`define SFGS_SUP_ADAPT     11:8
`define SFGS_TUNE_MODE     7:4
`define SFGS_SEL_TRIG      3:0
// ********
// Reset values and codes
// ********
`define SFGS_RST_ZERO      16'h0000
`define SFGS_RST_PCT       16'h0064
`define SFGS_PCT_DIV       32'h0000_0064
`define SFGS_TUNE_MANUAL   4'h4
`define SFGS_LPF_OFF       4'h1
`define SFGS_DEPTH_DEEP    2'h0
`define SFGS_DEPTH_MID     2'h1
`define SFGS_DEPTH_LOW     2'h2
// ********
// Adaptive band and detection
// ********
`define SFGS_BAND_LO_HZ    16'h0096
`define SFGS_BAND_HI_HZ    16'h01F4
`define SFGS_MAG_BASE      16'h1000
// ********
// Timing
// ********
`define SFGS_CLK_HZ        40'd20000000
`define SFGS_MS_PER_S      40'd1000
`define SFGS_SAVE_MIN      40'd60
`define SFGS_S_PER_MIN     40'd60
`define SFGS_TORQUE_FS_HZ  40'd20000
// Cutoff: spd*10/(2pi*(1+J*0.1)) = spd*100*1000/(6283*(10+J))
`define SFGS_LPF_NUM       40'd100000
`define SFGS_TWO_PI_MILLI  40'd6283
`define SFGS_INERTIA_ONE   16'h000A
// 2*pi in Q16
`define SFGS_TWO_PI_Q16    40'd411775
`define SFGS_ALPHA_MAX     40'h00_0001_0000
`define SFGS_GAIN_MAX      32'h0000_FFFF
`endif

// file: common/sfgs_pkg.sv
// Types shared by the servo filter and gain scheduling block
`default_nettype none
package sfgs_pkg;
	// Adaptive suppression selection
	typedef enum logic [3:0] {
		SFGS_ADAPT_OFF  = 4'b0000,
		SFGS_ADAPT_ON   = 4'b0001,
		SFGS_ADAPT_HOLD = 4'b0010
	} sfgs_adapt_t;
	// Gain change trigger source
	typedef enum logic [3:0] {
		SFGS_TRIG_NONE  = 4'b0000,
		SFGS_TRIG_EXT   = 4'b0001,
		SFGS_TRIG_CMD   = 4'b0010,
		SFGS_TRIG_DROOP = 4'b0011,
		SFGS_TRIG_SPEED = 4'b0100
	} sfgs_trig_t;
	typedef logic [15:0] sfgs_word_t;
endpackage : sfgs_pkg
`default_nettype wire

// file: rtl/sfgs_lag.sv
// First-order lag that moves one gain toward its target in millisecond steps
`include "sfgs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module sfgs_lag
	import sfgs_pkg::*;
(
	// Clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	// Control
	input  wire logic       i_snap,
	input  wire logic       i_tick,
	input  wire sfgs_word_t i_tc_ms,
	input  wire sfgs_word_t i_target,
	// Smoothed value
	output sfgs_word_t      o_value
);
	logic        [23:0] acc_ff;
	logic signed [24:0] diff;
	logic signed [24:0] step;

	// Remaining distance and this step's share of it
	always_comb begin
		diff = $signed({1'b0, i_target, 8'h00}) - $signed({1'b0, acc_ff});
		step = 25'(diff / $signed({9'h000, i_tc_ms}));
		// Truncation would stall short of the target
		if (step == 25'sh0 && diff != 25'sh0) begin
			step = (diff < 25'sh0) ? -25'sh1 : 25'sh1;
		end
	end

	// Lag starts from the present value, so a new target restarts it smoothly
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			acc_ff <= 24'h000000;
		end else if (i_snap || i_tc_ms == `SFGS_RST_ZERO) begin
			acc_ff <= {i_target, 8'h00};
		end else if (i_tick) begin
			acc_ff <= 24'($signed({1'b0, acc_ff}) + step);
		end
	end

	assign o_value = acc_ff[23:8];
endmodule : sfgs_lag
`default_nettype wire

// file: dv/sfgs_top_properties.sv
// Checker on the servo filter block ports
`timescale 1ns/1ps
`default_nettype none
module sfgs_props
	import sfgs_pkg::*;
#(
	parameter logic [39:0] SAVE_CYCLES = 40'h00_0000_0064
) (
	// Clock, reset and bus
	input wire logic        i_sys_clk,
	input wire logic        i_rst_n,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        o_wb_ack,
	input wire logic [31:0] o_wb_dat,
	// Filter and gain signals
	input wire logic        i_torque_valid,
	input wire logic        o_torque_valid,
	input wire logic        o_adapt_active,
	input wire logic [7:0]  o_notch1_freq,
	input wire logic [1:0]  o_notch1_depth,
	input wire logic        i_nv_load_valid,
	input wire sfgs_word_t  o_adapt_freq,
	input wire logic        o_nv_save,
	input wire logic        o_gain_changed,
	input wire sfgs_word_t  o_model_pos_gain,
	input wire sfgs_word_t  o_model_spd_gain
);
	// ********
	// Properties
	// ********
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// Cycles since the last save; the first pulse only arms the check
	logic [39:0] gap_ff;
	logic        seen_ff;
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			gap_ff  <= 40'h00_0000_0000;
			seen_ff <= 1'b0;
		end else if (o_nv_save) begin
			gap_ff  <= 40'h00_0000_0001;
			seen_ff <= 1'b1;
		end else begin
			gap_ff <= gap_ff + 40'h00_0000_0001;
		end
	end
	a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack stood longer than one cycle");
	a_ack_delay: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("request not answered in one cycle");
	a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
		else $error("read data not zero outside ack");
	a_notch1_off: assert property (o_adapt_active |->
		{o_notch1_freq, o_notch1_depth} == 10'h000)
		else $error("first notch live while adaptive on");
	a_torque_lat: assert property (i_torque_valid |=> o_torque_valid)
		else $error("torque sample lost");
	a_model_hold: assert property ($changed(o_gain_changed) |->
		$stable(o_model_pos_gain) && $stable(o_model_spd_gain))
		else $error("model gains moved on gain change");
	a_save_gap: assert property (o_nv_save && seen_ff |-> gap_ff == SAVE_CYCLES)
		else $error("save interval wrong");
	a_adapt_band: assert property ($changed(o_adapt_freq) && !$past(i_nv_load_valid, 2) |->
		o_adapt_freq >= 16'h0096 && o_adapt_freq <= 16'h01F4)
		else $error("adaptive frequency outside band");
endmodule : sfgs_props
bind sfgs_top sfgs_props #(.SAVE_CYCLES(SAVE_CYCLES)) u_props (.*);
`default_nettype wire

// file: dv/sfgs_loop.sv
// Control loop model: torque samples and resonance detector strobes
`timescale 1ns/1ps
`default_nettype none
module sfgs_loop
	import sfgs_pkg::*;
(
	// Clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	// Resonance request from the bench
	input  wire logic       i_res_req,
	input  wire sfgs_word_t i_res_f,
	input  wire sfgs_word_t i_res_m,
	// Toward the block
	output logic            o_res_valid,
	output sfgs_word_t      o_res_freq,
	output sfgs_word_t      o_res_mag,
	output logic            o_tq_valid,
	output sfgs_word_t      o_tq
);
	logic [1:0] ph_ff;
	// Torque every fourth cycle; data toggles between samples so stale values never match
	always_ff @(posedge i_sys_clk) begin
		ph_ff       <= i_rst_n ? ph_ff + 2'h1 : 2'h0;
		o_tq_valid  <= i_rst_n && ph_ff == 2'h3;
		o_tq        <= (ph_ff == 2'h3) ? sfgs_word_t'($urandom) : ~o_tq;
		o_res_valid <= i_rst_n && i_res_req;
		o_res_freq  <= i_res_req ? i_res_f : ~o_res_freq;
		o_res_mag   <= i_res_req ? i_res_m : ~o_res_mag;
	end
endmodule : sfgs_loop
`default_nettype wire

// file: dv/sfgs_top_bench.sv
// Self-checking bench for the servo filter and gain scheduling block
`timescale 1ns/1ps
`default_nettype none
module sfgs_top_bench
	import sfgs_pkg::*;
();
	// ********
	// Signals and instances
	// ********
	logic       i_sys_clk = 1'b0;
	logic       i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we, i_ext_gain_sel, i_res_valid;
	logic       i_nv_load_valid, i_torque_valid, o_wb_ack, o_nv_save, o_torque_valid;
	logic       o_adapt_active, o_gain_changed, res_req;
	logic [6:0] i_wb_adr;
	logic [3:0] i_wb_sel;
	logic [31:0] i_wb_dat, o_wb_dat, q;
	logic [1:0] i_nv_load_depth, o_nv_depth, o_notch1_depth, o_notch2_depth, o_adapt_depth;
	logic [7:0] o_notch1_freq, o_notch2_freq;
	logic [9:0] n1, n2;
	sfgs_word_t i_cmd_freq_kpps, i_droop_pulses, i_motor_speed_rpm, i_res_freq_hz, i_res_mag;
	sfgs_word_t i_nv_load_freq, i_torque, o_nv_freq, o_torque, o_adapt_freq, o_model_pos_gain;
	sfgs_word_t o_model_spd_gain, o_act_inertia, o_act_pos_gain, o_act_spd_gain, o_act_int_time;
	sfgs_word_t res_f, res_m, f, thr, b [4], p [4], e [4];
	int         n_errors = 0;
	int         tests_run = 0;
	always #25 i_sys_clk = ~i_sys_clk;
	sfgs_top #(.SAVE_CYCLES(40'h00_0000_0064), .MS_CYCLES(16'h0004)) dut (.i_sys_clk, .i_rst_n,
		.i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack,
		.i_ext_gain_sel, .i_cmd_freq_kpps, .i_droop_pulses, .i_motor_speed_rpm, .i_res_valid,
		.i_res_freq_hz, .i_res_mag, .i_nv_load_valid, .i_nv_load_freq, .i_nv_load_depth,
		.o_nv_save, .o_nv_freq, .o_nv_depth, .i_torque_valid, .i_torque, .o_torque_valid,
		.o_torque, .o_notch1_freq, .o_notch1_depth, .o_notch2_freq, .o_notch2_depth,
		.o_adapt_active, .o_adapt_freq, .o_adapt_depth, .o_model_pos_gain, .o_model_spd_gain,
		.o_act_inertia, .o_act_pos_gain, .o_act_spd_gain, .o_act_int_time, .o_gain_changed);
	sfgs_loop u_loop (.i_sys_clk, .i_rst_n, .i_res_req(res_req), .i_res_f(res_f),
		.i_res_m(res_m), .o_res_valid(i_res_valid), .o_res_freq(i_res_freq_hz),
		.o_res_mag(i_res_mag), .o_tq_valid(i_torque_valid), .o_tq(i_torque));
	// ********
	// Tasks
	// ********
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	// Classic cycle; read data taken at the ack edge only
	task automatic wb(input logic w, input logic [6:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_sys_clk);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we  <= w;
		i_wb_adr <= a;
		i_wb_dat <= d;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_errors++;
			end_sim();
		end
		q = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		@(posedge i_sys_clk);
	endtask : wb
	task automatic clk(input int k);
		repeat (k) @(posedge i_sys_clk);
	endtask : clk
	task automatic res(input sfgs_word_t fr, input sfgs_word_t m);
		@(posedge i_sys_clk);
		res_req <= 1'b1;
		res_f   <= fr;
		res_m   <= m;
		@(posedge i_sys_clk);
		res_req <= 1'b0;
		clk(5);
	endtask : res
	// Condition sources: only the selected one carries the value
	task automatic src(input int t, input sfgs_word_t v);
		i_cmd_freq_kpps   <= (t == 2) ? v : 16'h0000;
		i_droop_pulses    <= (t == 3) ? v : 16'h0000;
		i_motor_speed_rpm <= (t == 4) ? v : 16'h0000;
		clk(5);
	endtask : src
	function automatic logic [31:0] scl(input logic [31:0] v, input logic [31:0] r);
		return (v * r / 100 > 32'h0000_FFFF) ? 32'h0000_FFFF : v * r / 100;
	endfunction : scl
	// Watchdog well beyond the planned run
	initial begin
		#(50 * 30000);
		n_errors++;
		end_sim();
	end
	// ********
	// Main sequence
	// ********
	initial begin
		{i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we, i_ext_gain_sel, i_nv_load_valid, res_req} = '0;
		{i_wb_adr, i_wb_dat, i_nv_load_freq, i_nv_load_depth, res_f, res_m} = '0;
		{i_cmd_freq_kpps, i_droop_pulses, i_motor_speed_rpm} = '0;
		i_wb_sel = 4'hF;
		q = $urandom(32'hF08F1887);
		clk(20);
		i_rst_n <= 1'b1;
		// Reset values, unmapped and read-only places
		wb(0, 7'h08, 0); chk("suppress", q, 32'h0000_0000);
		wb(0, 7'h2C, 0); chk("pos pct", q, 32'h0000_0064);
		wb(1, 7'h44, $urandom); wb(0, 7'h44, 0); chk("ro act", q, 32'h0000_0000);
		wb(0, 7'h7C, 0); chk("unmapped", q, 32'h0000_0000);
		$display("test reset done");
		// Notches: same fields, second one independent of adaptive mode
		n1 = 10'($urandom);
		n2 = 10'($urandom);
		wb(1, 7'h00, n1); wb(1, 7'h04, n2); clk(3);
		chk("notch1", {o_notch1_depth, o_notch1_freq}, n1);
		chk("notch2", {o_notch2_depth, o_notch2_freq}, n2);
		wb(1, 7'h08, 32'h0000_0101); clk(3);
		chk("notch1 off", {o_notch1_depth, o_notch1_freq}, 0);
		chk("adapt on", o_adapt_active, 1);
		chk("notch2 on", {o_notch2_depth, o_notch2_freq}, n2);
		$display("test notch done");
		// Adaptive tracking, lower band edge, sensitivity and hold
		res(16'h0096, 16'h4000); chk("edge", {o_adapt_depth, o_adapt_freq}, 32'h0000_0096);
		res(16'h0258, 16'h4000); chk("out band", o_adapt_freq, 16'h0096);
		f = 16'($urandom_range(16'h0097, 16'h01F4));
		res(f, 16'h2000); chk("track", {o_adapt_depth, o_adapt_freq}, {2'h1, f});
		res(16'h00FA, 16'h0900); chk("weak", o_adapt_freq, f);
		wb(1, 7'h08, 32'h0000_0201);
		res(16'h012C, 16'h4000); chk("held", o_adapt_freq, f);
		wb(1, 7'h08, 32'h0000_0111);
		res(16'h00C8, 16'h0900); chk("sens", {o_adapt_depth, o_adapt_freq}, 32'h0002_00C8);
		$display("test adaptive done");
		// Low-pass off: torque passes raw one cycle later
		repeat (4) begin
			do @(posedge i_sys_clk); while (i_torque_valid !== 1'b1);
			f = i_torque;
			@(posedge i_sys_clk);
			chk("raw torque", {o_torque_valid, o_torque}, {1'b1, f});
		end
		$display("test torque done");
		// Gain changing by external input, manual tuning
		b[0] = 16'h0028;
		p[1] = 16'h0064;
		for (int i = 1; i < 4; i++) b[i] = 16'($urandom_range(1000, 3000));
		for (int i = 2; i < 4; i++) p[i] = 16'($urandom_range(120, 250));
		for (int i = 0; i < 4; i++) wb(1, 7'h18 + 7'(4 * i), b[i]);
		for (int i = 1; i < 4; i++) wb(1, 7'h28 + 7'(4 * i), p[i]);
		wb(1, 7'h28, 32'h0000_0064);
		e[0] = 16'h0064;
		for (int i = 1; i < 4; i++) e[i] = 16'(scl(b[i], p[i]));
		thr = 16'($urandom);
		wb(1, 7'h10, thr); wb(1, 7'h14, ~thr);
		wb(1, 7'h0C, 32'h0000_0040); wb(1, 7'h38, 1); wb(1, 7'h40, 0);
		for (int s = 1; s >= 0; s--) begin
			i_ext_gain_sel <= s[0];
			clk(10);
			chk("changed", o_gain_changed, s[0]);
			chk("inertia", o_act_inertia, s ? e[0] : b[0]);
			chk("pos", o_act_pos_gain, s ? e[1] : b[1]);
			chk("spd", o_act_spd_gain, s ? e[2] : b[2]);
			chk("int", o_act_int_time, s ? e[3] : b[3]);
			chk("model", {o_model_pos_gain, o_model_spd_gain}, {thr, ~thr});
		end
		wb(1, 7'h0C, 32'h0000_0010); i_ext_gain_sel <= 1'b1; clk(10);
		chk("auto tune", o_gain_changed, 0);
		i_ext_gain_sel <= 1'b0; wb(1, 7'h0C, 32'h0000_0040); clk(3);
		wb(0, 7'h54, 0); chk("cutoff", q, b[2] * 100000 / (6283 * 50));
		$display("test gain change done");
		// Threshold triggers: one below stays, at threshold changes
		thr = 16'($urandom_range(100, 1000));
		wb(1, 7'h3C, thr);
		for (int t = 2; t < 5; t++) begin
			wb(1, 7'h38, t);
			src(t, thr - 16'h0001); chk("below", o_gain_changed, 0);
			src(t, thr); chk("at thr", o_gain_changed, 1);
			src(t, 16'h0000);
		end
		// Smoothed transition with a 5 ms constant
		wb(1, 7'h38, 1); wb(1, 7'h40, 5); i_ext_gain_sel <= 1'b1; clk(12);
		chk("lag mid", o_act_spd_gain > b[2] && o_act_spd_gain < e[2], 1);
		clk(4000); chk("lag end", o_act_spd_gain, e[2]);
		$display("test smoothing done");
		// Periodic save and power-on load
		f = 0;
		while (o_nv_save !== 1'b1 && f < 300) begin
			@(posedge i_sys_clk);
			f++;
		end
		if (f >= 300) begin
			n_errors++;
			end_sim();
		end
		@(posedge i_sys_clk);
		chk("save", {o_nv_depth, o_nv_freq}, 32'h0002_00C8);
		i_nv_load_valid <= 1'b1; i_nv_load_freq <= 16'h0141; i_nv_load_depth <= 2'h1;
		@(posedge i_sys_clk); i_nv_load_valid <= 1'b0; clk(4);
		chk("load", {o_adapt_depth, o_adapt_freq}, 32'h0001_0141);
		$display("test save done");
		end_sim();
	end
endmodule : sfgs_top_bench
`default_nettype wire
